// File: logic/irq_ctrl_regs.vh
// Purpose: Constants for the interrupt controller and external request unit
// Assumes: Byte-wide register port, 16-bit CPU address space
// Notes: Bit positions of the status/control register are fixed here
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH
// ==========================================================================
// Register offsets
`define ADDR_EXT_IRQ_STATUS_CONTROL 8'h1F
// ==========================================================================
// Status/control field positions
`define BIT_PORT_EDGE_REQUEST_ENABLE 1
`define BIT_EXTERNAL_REQUEST_ACK 2
`define BIT_PORT_EDGE_REQUEST_FLAG 3
`define BIT_PIN_REQUEST_FLAG 5
`define BIT_PIN_REQUEST_ENABLE 7
// ==========================================================================
// Reset values
`define RST_PIN_REQUEST_ENABLE 1'h1
`define RST_PORT_EDGE_REQUEST_ENABLE 1'h0
`define RST_PIN_REQUEST_FLAG 1'h0
`define RST_PORT_EDGE_REQUEST_FLAG 1'h0
// ==========================================================================
// Vector addresses (high byte of each pair)
`define VEC_RESET 16'h3FFE
`define VEC_SOFTWARE_TRAP 16'h3FFC
`define VEC_EXTERNAL 16'h3FFA
`define VEC_TIMER16 16'h3FF8
`define VEC_NETWORK 16'h3FF6
`define VEC_SERIAL 16'h3FF4
`define VEC_CORE_TIMER 16'h3FF2
`define VEC_GAUGE 16'h3FF0
// ==========================================================================
// Timing
`define STACKING_OVERHEAD_CYCLES 4'hA
`endif

// File: logic/irq_ctrl.v
// Purpose: CPU-side interrupt arbitration, vectoring and external request unit
// Assumes: CPU core sequencer drives the instruction-boundary handshake
// Notes: One clock, synchronous active-high reset
//
// What this block does
// - Requests wait for instruction end; stack, set mask, then pick source.
// - Service starts only with mask clear and the source enabled.
// - Among pending sources the highest vector address wins.
// - Vector addresses come from the sixteen bytes 3FF0 to 3FFF.
// - Reset loads the top vector pair and sets the mask.
// - Software trap ignores mask; pending enabled requests are taken first.
// - Entry latency stays within longest instruction plus ten cycles.
// - Return restores stacked state and resumes at the next instruction.
// - Pin-level branches see only the raw pin level.
// - Port latch and pin latch OR into one external request.
// - Port pins ANDed; falling edge of that sets the port flag.
// - A port pin counts only with direction and data bits both clear.
// - Edge-only option: only the pin edge latch sets the pin flag.
// - Level option: a low pin level also sets the pin flag.
// - Pin enable gates pin flag; port enable gates only the port flag's request, not its setting.
// - Entering external service clears pin flag, keeps port flag.
// - Writing one to acknowledge clears both flags; zero does nothing.
// - Port flag read-only, acknowledge reads zero, unused bits read zero.
// - Reset clears flags, sets pin enable, clears port enable, sets mask.
// - Stop or wait forces pin enable to one; port enable unchanged.
// - Pin flag sets only while pin enable is set.
// - External request synchronised first, then its falling edge is detected.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "irq_ctrl_regs.vh"
module irq_ctrl
(
  input wire clk_sys_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire irq_pin_n_i,
  input wire [7:0] port_c_pin_i,
  input wire [7:0] port_c_dir_i,
  input wire [7:0] port_c_data_i,
  input wire level_select_i,
  input wire [5:0] periph_req_i,
  input wire insn_done_i,
  input wire swi_exec_i,
  input wire rti_exec_i,
  input wire stop_wait_exec_i,
  input wire mask_clear_i,
  input wire mask_set_i,
  output reg take_irq_o,
  output reg take_swi_o,
  output reg take_reset_o,
  output reg stack_o,
  output reg unstack_o,
  output reg vector_valid_o,
  output reg [15:0] vector_addr_o,
  output reg int_mask_o,
  output reg pin_level_o
);
// ==========================================================================
// Sequencer states
localparam [4:0] S_RESET = 5'h01;
localparam [4:0] S_RUN = 5'h02;
localparam [4:0] S_STACK = 5'h04;
localparam [4:0] S_VECTOR = 5'h08;
localparam [4:0] S_UNSTACK = 5'h10;
// Source indices, 0 is highest priority
localparam [2:0] SRC_NONE = 3'h7;

function [15:0] vec_of;
  input [2:0] src;
  begin
    case (src)
      3'h0: vec_of = `VEC_EXTERNAL;
      3'h1: vec_of = `VEC_TIMER16;
      3'h2: vec_of = `VEC_NETWORK;
      3'h3: vec_of = `VEC_SERIAL;
      3'h4: vec_of = `VEC_CORE_TIMER;
      3'h5: vec_of = `VEC_GAUGE;
      default: vec_of = `VEC_SOFTWARE_TRAP;
    endcase
  end
endfunction

// ==========================================================================
// Input synchronisers
reg [8:0] sync1;
reg [8:0] sync2;
reg [8:0] sync_d;
always @(posedge clk_sys_i)
begin
  if (rst_i)
  begin
    sync1 <= 9'h1FF;
    sync2 <= 9'h1FF;
    sync_d <= 9'h1FF;
  end
  else
  begin
    sync1 <= {irq_pin_n_i, port_c_pin_i};
    sync2 <= sync1;
    sync_d <= sync2;
  end
end

// ==========================================================================
// Port C qualifier and combined edge
wire [7:0] port_qual;
genvar gi;
generate
  for (gi = 0; gi < 8; gi = gi + 1)
  begin : g_port
    assign port_qual[gi] = sync2[gi] | port_c_dir_i[gi] | port_c_data_i[gi];
  end
endgenerate
reg port_and_d;
wire port_and = &port_qual;
wire port_fall = port_and_d & ~port_and;
wire pin_fall = sync_d[8] & ~sync2[8];
wire pin_low = ~sync2[8];

// ==========================================================================
// Combined port level, held for edge detection
always @(posedge clk_sys_i)
begin
  if (rst_i)
    port_and_d <= 1'h1;
  else
    port_and_d <= port_and;
end

// ==========================================================================
// Register decode
reg pin_flag;
reg port_flag;
reg pin_en;
reg port_en;
reg [4:0] state;
reg [2:0] cur_src;
wire reg_hit = reg_addr_i == `ADDR_EXT_IRQ_STATUS_CONTROL;
wire reg_wr_hit = reg_wr_i & reg_hit;
wire reg_rd_hit = reg_rd_i & reg_hit;
wire ack = reg_wr_hit & reg_wdata_i[`BIT_EXTERNAL_REQUEST_ACK];
wire next_pin_en = reg_wr_hit ? reg_wdata_i[`BIT_PIN_REQUEST_ENABLE] : pin_en;
wire next_port_en = reg_wr_hit ? reg_wdata_i[`BIT_PORT_EDGE_REQUEST_ENABLE] : port_en;
wire pin_set = pin_en & (pin_fall | (level_select_i & pin_low));
wire ext_entry = (state == S_VECTOR) & (cur_src == 3'h0);

function [7:0] status_byte;
  input f_pin_en;
  input f_pin_flag;
  input f_port_flag;
  input f_port_en;
  begin
    status_byte = 8'h00;
    status_byte[`BIT_PIN_REQUEST_ENABLE] = f_pin_en;
    status_byte[`BIT_PIN_REQUEST_FLAG] = f_pin_flag;
    status_byte[`BIT_PORT_EDGE_REQUEST_FLAG] = f_port_flag;
    status_byte[`BIT_PORT_EDGE_REQUEST_ENABLE] = f_port_en;
  end
endfunction

// ==========================================================================
// Pin request enable
always @(posedge clk_sys_i)
begin
  if (rst_i)
    pin_en <= `RST_PIN_REQUEST_ENABLE;
  else if (stop_wait_exec_i)
    pin_en <= 1'h1;
  else
    pin_en <= next_pin_en;
end

// ==========================================================================
// Port edge request enable
always @(posedge clk_sys_i)
begin
  if (rst_i)
    port_en <= `RST_PORT_EDGE_REQUEST_ENABLE;
  else
    port_en <= next_port_en;
end

// ==========================================================================
// Pin request flag, a new request wins over clearing
always @(posedge clk_sys_i)
begin
  if (rst_i)
    pin_flag <= `RST_PIN_REQUEST_FLAG;
  else if (pin_set)
    pin_flag <= 1'h1;
  else if (ack | ext_entry)
    pin_flag <= 1'h0;
end

// ==========================================================================
// Port edge request flag, cleared by acknowledge only
always @(posedge clk_sys_i)
begin
  if (rst_i)
    port_flag <= `RST_PORT_EDGE_REQUEST_FLAG;
  else if (port_fall)
    port_flag <= 1'h1;
  else if (ack)
    port_flag <= 1'h0;
end

// ==========================================================================
// Read data one cycle after strobe, zero otherwise
always @(posedge clk_sys_i)
begin
  if (rst_i)
    reg_rdata_o <= 8'h00;
  else if (reg_rd_hit)
    reg_rdata_o <= status_byte(pin_en, pin_flag, port_flag, port_en);
  else
    reg_rdata_o <= 8'h00;
end

// ==========================================================================
// Priority selection
wire ext_req = (pin_flag & pin_en) | (port_flag & port_en);
wire [5:0] pend = {periph_req_i[5:1], ext_req};

function [2:0] first_src;
  input [5:0] req;
  begin
    if (req[0])
      first_src = 3'h0;
    else if (req[1])
      first_src = 3'h1;
    else if (req[2])
      first_src = 3'h2;
    else if (req[3])
      first_src = 3'h3;
    else if (req[4])
      first_src = 3'h4;
    else if (req[5])
      first_src = 3'h5;
    else
      first_src = SRC_NONE;
  end
endfunction

wire [2:0] pick = first_src(pend);

// ==========================================================================
// Sequencer
reg [3:0] stack_cnt;
reg is_swi;
reg swi_pend;
wire irq_go = insn_done_i & ~int_mask_o & (pick != SRC_NONE);
wire swi_go = swi_exec_i | swi_pend;
wire stack_done = stack_cnt == `STACKING_OVERHEAD_CYCLES - 4'h2;

// ==========================================================================
// Trap request held until the run state can take it
always @(posedge clk_sys_i)
begin
  if (rst_i)
    swi_pend <= 1'h0;
  else if ((state == S_RUN) & ~irq_go)
    swi_pend <= 1'h0;
  else if (swi_exec_i)
    swi_pend <= 1'h1;
end

// ==========================================================================
// Stacking cycle counter
always @(posedge clk_sys_i)
begin
  if (rst_i)
    stack_cnt <= 4'h0;
  else if (state == S_STACK)
    stack_cnt <= stack_cnt + 4'h1;
  else
    stack_cnt <= 4'h0;
end

// ==========================================================================
// Raw pin level for the pin-level branches
always @(posedge clk_sys_i)
begin
  if (rst_i)
    pin_level_o <= 1'h1;
  else
    pin_level_o <= sync2[8];
end

always @(posedge clk_sys_i)
begin
  if (rst_i)
  begin
    state <= S_RESET;
    int_mask_o <= 1'h1;
    cur_src <= SRC_NONE;
    is_swi <= 1'h0;
    take_irq_o <= 1'h0;
    take_swi_o <= 1'h0;
    take_reset_o <= 1'h0;
    stack_o <= 1'h0;
    unstack_o <= 1'h0;
    vector_valid_o <= 1'h0;
    vector_addr_o <= `VEC_RESET;
  end
  else
  begin
    take_irq_o <= 1'h0;
    take_swi_o <= 1'h0;
    take_reset_o <= 1'h0;
    vector_valid_o <= 1'h0;
    unstack_o <= 1'h0;
    case (state)
      S_RESET:
      begin
        vector_addr_o <= `VEC_RESET;
        vector_valid_o <= 1'h1;
        take_reset_o <= 1'h1;
        state <= S_RUN;
      end
      S_RUN:
      begin
        if (mask_set_i)
          int_mask_o <= 1'h1;
        else if (mask_clear_i)
          int_mask_o <= 1'h0;
        if (irq_go)
        begin
          is_swi <= 1'h0;
          take_irq_o <= 1'h1;
          stack_o <= 1'h1;
          state <= S_STACK;
        end
        else if (swi_go)
        begin
          is_swi <= 1'h1;
          take_swi_o <= 1'h1;
          stack_o <= 1'h1;
          state <= S_STACK;
        end
        else if (rti_exec_i)
        begin
          unstack_o <= 1'h1;
          state <= S_UNSTACK;
        end
      end
      S_STACK:
      begin
        if (stack_done)
        begin
          stack_o <= 1'h0;
          int_mask_o <= 1'h1;
          cur_src <= is_swi ? SRC_NONE : pick;
          state <= S_VECTOR;
        end
      end
      S_VECTOR:
      begin
        vector_addr_o <= is_swi ? `VEC_SOFTWARE_TRAP : vec_of(cur_src);
        vector_valid_o <= 1'h1;
        state <= S_RUN;
      end
      S_UNSTACK:
      begin
        int_mask_o <= 1'h0;
        state <= S_RUN;
      end
      default:
        state <= S_RESET;
    endcase
  end
end
endmodule // irq_ctrl

// File: testbench/irq_ctrl_asserts.sv
// Purpose: Port checks for irq_ctrl
// Assumes: Sync active-high reset
// Notes: Bound after the module
`timescale 1ns/1ps
module irq_ctrl_asserts
(
  input wire clk_sys_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire irq_pin_n_i,
  input wire take_irq_o,
  input wire take_swi_o,
  input wire take_reset_o,
  input wire stack_o,
  input wire unstack_o,
  input wire vector_valid_o,
  input wire [15:0] vector_addr_o,
  input wire int_mask_o,
  input wire pin_level_o
);
  // ======
  // Checks
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  take_stack_a:
    assert property (take_irq_o |-> stack_o) else $error("stack");
  stack_mask_a:
    assert property (take_irq_o |-> ##9 int_mask_o) else $error("mask");
  take_unmask_a:
    assert property (take_irq_o |-> $past(int_mask_o) == 1'b0) else $error("masked");
  irq_lat_a:
    assert property (take_irq_o |-> ##10 vector_valid_o) else $error("latency");
  swi_vec_a:
    assert property (take_swi_o |-> ##10 vector_valid_o && vector_addr_o == 16'h3FFC)
      else $error("trap");
  reset_vec_a:
    assert property (take_reset_o |-> vector_valid_o && vector_addr_o == 16'h3FFE)
      else $error("reset");
  rti_mask_a:
    assert property (unstack_o |=> !int_mask_o) else $error("return");
  rd_idle_a:
    assert property (!(reg_rd_i && reg_addr_i == 8'h1F) |=> reg_rdata_o == 8'h00)
      else $error("idle");
  rd_unused_a:
    assert property (reg_rd_i |=> (reg_rdata_o & 8'h55) == 8'h00) else $error("bits");
  pin_level_a:
    assert property ($stable(irq_pin_n_i)[*5] |-> pin_level_o == irq_pin_n_i)
      else $error("level");
endmodule // irq_ctrl_asserts
bind irq_ctrl irq_ctrl_asserts irq_ctrl_asserts_i (.clk_sys_i, .rst_i, .reg_addr_i,
  .reg_rd_i, .reg_rdata_o, .irq_pin_n_i, .take_irq_o, .take_swi_o, .take_reset_o,
  .stack_o, .unstack_o, .vector_valid_o, .vector_addr_o, .int_mask_o, .pin_level_o);

// File: testbench/cpu_seq_model.sv
// Purpose: CPU sequencer stand-in
// Assumes: Three-cycle instructions
// Notes: Halts while stacking
`timescale 1ns/1ps
module cpu_seq_model
(
  input wire clk_sys_i,
  input wire rst_i,
  input wire stack_i,
  output reg insn_done_o
);
  // ======
  // Instruction boundaries
  reg [1:0] cnt;
  always @(posedge clk_sys_i)
  begin
    insn_done_o <= 1'b0;
    if (rst_i || stack_i)
      cnt <= 2'h0;
    else if (cnt == 2'h2)
    begin
      cnt <= 2'h0;
      insn_done_o <= 1'b1;
    end
    else
      cnt <= cnt + 2'h1;
  end
endmodule // cpu_seq_model

// File: testbench/mcu_interrupt_and_ext_irq_logic_test.sv
// Purpose: Bench for irq_ctrl
// Assumes: 250 MHz clock
// Notes: Queued results
`timescale 1ns/1ps
`define CHK(n,e,a) begin total_checks++; if ((a) !== (e)) begin errors++; \
$display("MISMATCH %s exp %h got %h", n, e, a); end end
module mcu_interrupt_and_ext_irq_logic_test;
  reg clk_sys_i = 1'b0;
  reg rst_i = 1'b1;
  reg reg_wr_i = 1'b0, reg_rd_i = 1'b0, irq_pin_n_i = 1'b1, rd_q = 1'b0;
  reg swi_exec_i = 1'b0, rti_exec_i = 1'b0, stop_wait_exec_i = 1'b0, mask_clear_i = 1'b0;
  reg [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, port_c_pin_i = 8'hFF, er;
  reg [7:0] port_c_data_i = 8'h00, port_c_dir_i = 8'h00;
  reg level_select_i = 1'b0;
  reg [5:0] periph_req_i = 6'h00;
  reg [15:0] ev;
  reg [7:0] rq[$];
  reg [15:0] vq[$];
  integer errors = 0, total_checks = 0, cyc = 0, k, i;
  wire [7:0] reg_rdata_o;
  wire [15:0] vector_addr_o;
  wire take_irq_o, take_swi_o, take_reset_o, stack_o, unstack_o;
  wire vector_valid_o, int_mask_o, pin_level_o, insn_done_i;
  irq_ctrl irq_ctrl_i (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .irq_pin_n_i, .port_c_pin_i, .port_c_dir_i, .port_c_data_i,
    .level_select_i, .periph_req_i, .insn_done_i, .swi_exec_i, .rti_exec_i,
    .stop_wait_exec_i, .mask_clear_i, .mask_set_i(1'b0), .take_irq_o, .take_swi_o,
    .take_reset_o, .stack_o, .unstack_o, .vector_valid_o, .vector_addr_o, .int_mask_o,
    .pin_level_o);
  cpu_seq_model cpu_seq_model_i (.clk_sys_i, .rst_i, .stack_i(stack_o),
    .insn_done_o(insn_done_i));
  always #2 clk_sys_i = ~clk_sys_i;
  // ======
  // Result watcher
  always @(posedge clk_sys_i)
    rd_q <= reg_rd_i;
  always @(negedge clk_sys_i)
  begin
    if (rd_q)
    begin
      er = rq.pop_front();
      `CHK("rdata", er, reg_rdata_o)
    end
    if (vector_valid_o)
    begin
      ev = (vq.size() != 0) ? vq.pop_front() : 16'hFFFF;
      `CHK("vector", ev, vector_addr_o)
    end
  end
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      summarize;
    end
  end
  task summarize;
  begin
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    rq.push_back(e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
  end
  endtask
  task strobe(input [3:0] s);
  begin
    {mask_clear_i, stop_wait_exec_i, swi_exec_i, rti_exec_i} <= s;
    @(posedge clk_sys_i);
    {mask_clear_i, stop_wait_exec_i, swi_exec_i, rti_exec_i} <= 4'h0;
    @(posedge clk_sys_i);
  end
  endtask
  task fall(input n, input [7:0] p);
  begin
    irq_pin_n_i <= n;
    port_c_pin_i <= p;
    repeat (6) @(posedge clk_sys_i);
    irq_pin_n_i <= 1'b1;
    port_c_pin_i <= 8'hFF;
    @(posedge clk_sys_i);
  end
  endtask
  task wait_vec;
    repeat (100) if (vq.size() != 0) @(posedge clk_sys_i);
  endtask
  // ======
  // Main sequence
  initial
  begin
    k = $urandom(33);
    vq.push_back(16'h3FFE);
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rd(8'h1F, 8'h80);
    wr(8'h1E, 8'hFF);
    rd(8'h1E, 8'h00);
    wr(8'h1F, 8'hFF);
    rd(8'h1F, 8'h82);
    fall(1'b0, 8'hFF);
    rd(8'h1F, 8'hA2);
    k = $urandom % 8;
    port_c_data_i <= 8'h01 << k;
    fall(1'b1, ~(8'h01 << k));
    rd(8'h1F, 8'hA2);
    port_c_data_i <= 8'h00;
    fall(1'b1, ~(8'h01 << k));
    wr(8'h1F, 8'h82);
    rd(8'h1F, 8'hAA);
    wr(8'h1F, 8'h86);
    rd(8'h1F, 8'h82);
    periph_req_i <= 6'h3E;
    fall(1'b0, 8'hFE);
    vq.push_back(16'h3FFA);
    strobe(4'h8);
    wait_vec;
    rd(8'h1F, 8'h8A);
    wr(8'h1F, 8'h86);
    for (i = 1; i < 6; i++)
    begin
      periph_req_i <= 6'h3F << i;
      vq.push_back(16'h3FFA - 2 * i);
      strobe(4'h1);
      wait_vec;
    end
    periph_req_i <= 6'h00;
    strobe(4'h1);
    vq.push_back(16'h3FFC);
    strobe(4'h2);
    wait_vec;
    wr(8'h1F, 8'h02);
    fall(1'b0, 8'hFF);
    rd(8'h1F, 8'h02);
    strobe(4'h4);
    rd(8'h1F, 8'h82);
    port_c_dir_i <= 8'h01 << k;
    fall(1'b1, ~(8'h01 << k));
    rd(8'h1F, 8'h82);
    port_c_dir_i <= 8'h00;
    level_select_i <= 1'b1;
    irq_pin_n_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    wr(8'h1F, 8'h86);
    rd(8'h1F, 8'hA2);
    irq_pin_n_i <= 1'b1;
    level_select_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    wr(8'h1F, 8'h86);
    rd(8'h1F, 8'h82);
    `CHK("left", 32'h0, vq.size() + rq.size())
    summarize;
  end
endmodule // mcu_interrupt_and_ext_irq_logic_test
